//--- design/cwff_pkg.sv
package cwff_pkg;

  localparam int unsigned CWFF_ADDR_W = 7;
  localparam int unsigned CWFF_DATA_W = 8;
  localparam int unsigned CWFF_ID_W = 29;
  localparam int unsigned CWFF_DLC_W = 4;

  // Register addresses on the serial port
  localparam logic [6:0] CWFF_ADDR_WAKE_ID_MID_HIGH = 7'h24;
  localparam logic [6:0] CWFF_ADDR_WAKE_ID_MID_LOW = 7'h25;
  localparam logic [6:0] CWFF_ADDR_WAKE_ID_LOW_FLAGS = 7'h26;
  localparam logic [6:0] CWFF_ADDR_WAKE_MASK_TOP = 7'h27;
  localparam logic [6:0] CWFF_ADDR_WAKE_MASK_MID_HIGH = 7'h28;
  localparam logic [6:0] CWFF_ADDR_WAKE_MASK_MID_LOW = 7'h29;
  localparam logic [6:0] CWFF_ADDR_WAKE_MASK_LOW = 7'h2a;
  localparam logic [6:0] CWFF_ADDR_WAKE_LENGTH_CODE = 7'h2b;

  // Field positions in the low identifier, low mask and length code registers
  localparam int unsigned CWFF_POS_ID_LOW_MSB = 6;
  localparam int unsigned CWFF_POS_ID_LOW_LSB = 2;
  localparam int unsigned CWFF_POS_RTR = 1;
  localparam int unsigned CWFF_POS_IDE = 0;
  localparam int unsigned CWFF_POS_DLC_MSB = 3;

  // Standard identifiers sit in identifier bits 28 down to 18
  localparam logic [28:0] CWFF_STD_ID_FIELD = 29'h1ffc0000;

  localparam logic [7:0] CWFF_RST_BYTE = 8'h00;
  localparam logic [7:0] CWFF_READ_UNMAPPED = 8'h00;

  typedef struct packed {
    logic [7:0] id_top;
    logic [7:0] id_mid_high;
    logic [7:0] id_mid_low;
    logic [4:0] id_low;
    logic rtr;
    logic ide;
    logic [7:0] mask_top;
    logic [7:0] mask_mid_high;
    logic [7:0] mask_mid_low;
    logic [4:0] mask_low;
    logic [3:0] dlc;
  } cwff_cfg_t;

  typedef struct packed {
    logic [28:0] id;
    logic ide;
    logic rtr;
    logic [3:0] dlc;
  } cwff_frame_t;

endpackage : cwff_pkg

//--- design/cwff_match.sv
module cwff_match
  import cwff_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input cwff_cfg_t cfg,
  input wire logic frame_valid,
  input cwff_frame_t frame,
  output logic match
);

  typedef struct packed {
    logic match;
  } cwff_match_state_t;

  cwff_match_state_t s_q;
  cwff_match_state_t s_d;
  logic [28:0] cfg_id;
  logic [28:0] cfg_mask;
  logic id_ok;

  always_comb begin
    cfg_id = {cfg.id_top, cfg.id_mid_high, cfg.id_mid_low, cfg.id_low};
    cfg_mask = {cfg.mask_top, cfg.mask_mid_high, cfg.mask_mid_low, cfg.mask_low};
    // Standard frames carry no extension bits, so only 28..18 take part
    if (!cfg.ide) begin
      cfg_mask = cfg_mask & CWFF_STD_ID_FIELD;
    end
    id_ok = ((frame.id ^ cfg_id) & cfg_mask) == 29'h00000000;
    s_d = s_q;
    // Remote frames are expected to be refused by config, but the flag is still compared
    s_d.match = enable && frame_valid && id_ok && (frame.ide == cfg.ide)
      && (frame.rtr == cfg.rtr) && (frame.dlc == cfg.dlc);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign match = s_q.match;

endmodule : cwff_match

//--- design/cwff_top.sv
// How it works
// - Register at 0x24 holds wake identifier bits 20..13, all eight bits writable.
// - Register at 0x25 holds wake identifier bits 12..5, all eight bits writable.
// - Identifier bits 4..0 live in bits 6..2 of register 0x26.
// - Bit 1 of 0x26 is expected remote flag: 0 data, 1 remote.
// - Bit 0 of 0x26 selects standard 11-bit or extended 29-bit identifier.
// - Mask bit one compares that identifier bit; zero ignores it.
// - Mask registers 0x27, 0x28, 0x29 cover identifier bits 28..21, 20..13, 12..5.
// - Mask bits 4..0 sit in 0x2a bits 6..2; other bits reserved.
// - Reserved bits ignore writes and always read back zero.
// - Register 0x2b holds a four-bit length code in bits 3..0.
// - Received length code must equal configured code in all four bits.
// - Power-on and soft reset clear all registers; restart leaves them alone.
// - Standard identifiers are placed and compared in identifier bits 28..18.
// - Config-valid flag clears on wake, match, power-on, soft reset, or any configuration write.
module cwff_top
  import cwff_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SOFT_RST,
  input wire logic [6:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic [7:0] CFG_ID_TOP,
  input wire logic CFG_VALID_SET,
  input wire logic WAKE_EVENT,
  output logic CONFIG_VALID_FLAG,
  input wire logic FRAME_VALID,
  input wire logic [28:0] FRAME_ID,
  input wire logic FRAME_IDE,
  input wire logic FRAME_RTR,
  input wire logic [3:0] FRAME_DLC,
  output logic WAKE_MATCH
);

  typedef struct packed {
    cwff_cfg_t cfg;
    logic cfg_valid;
    logic [7:0] rdata;
  } cwff_state_t;

  cwff_state_t s_q;
  cwff_state_t s_d;
  cwff_cfg_t cfg_live;
  cwff_frame_t frame;
  logic match;
  logic cfg_write;

  function automatic logic [7:0] read_reg(input logic [6:0] addr, input cwff_cfg_t c);
    logic [7:0] v;
    v = CWFF_READ_UNMAPPED;
    if (addr == CWFF_ADDR_WAKE_ID_MID_HIGH) begin
      v = c.id_mid_high;
    end else if (addr == CWFF_ADDR_WAKE_ID_MID_LOW) begin
      v = c.id_mid_low;
    end else if (addr == CWFF_ADDR_WAKE_ID_LOW_FLAGS) begin
      v = {1'b0, c.id_low, c.rtr, c.ide};
    end else if (addr == CWFF_ADDR_WAKE_MASK_TOP) begin
      v = c.mask_top;
    end else if (addr == CWFF_ADDR_WAKE_MASK_MID_HIGH) begin
      v = c.mask_mid_high;
    end else if (addr == CWFF_ADDR_WAKE_MASK_MID_LOW) begin
      v = c.mask_mid_low;
    end else if (addr == CWFF_ADDR_WAKE_MASK_LOW) begin
      v = {1'b0, c.mask_low, 2'b00};
    end else if (addr == CWFF_ADDR_WAKE_LENGTH_CODE) begin
      v = {4'h0, c.dlc};
    end
    return v;
  endfunction : read_reg

  function automatic logic in_block(input logic [6:0] addr);
    return (addr >= CWFF_ADDR_WAKE_ID_MID_HIGH) && (addr <= CWFF_ADDR_WAKE_LENGTH_CODE);
  endfunction : in_block

  assign cfg_write = REG_WR && in_block(REG_ADDR);

  always_comb begin
    s_d = s_q;
    s_d.cfg.id_top = CFG_ID_TOP;
    if (REG_WR) begin
      if (REG_ADDR == CWFF_ADDR_WAKE_ID_MID_HIGH) begin
        s_d.cfg.id_mid_high = REG_WDATA;
      end else if (REG_ADDR == CWFF_ADDR_WAKE_ID_MID_LOW) begin
        s_d.cfg.id_mid_low = REG_WDATA;
      end else if (REG_ADDR == CWFF_ADDR_WAKE_ID_LOW_FLAGS) begin
        s_d.cfg.id_low = REG_WDATA[CWFF_POS_ID_LOW_MSB:CWFF_POS_ID_LOW_LSB];
        s_d.cfg.rtr = REG_WDATA[CWFF_POS_RTR];
        s_d.cfg.ide = REG_WDATA[CWFF_POS_IDE];
      end else if (REG_ADDR == CWFF_ADDR_WAKE_MASK_TOP) begin
        s_d.cfg.mask_top = REG_WDATA;
      end else if (REG_ADDR == CWFF_ADDR_WAKE_MASK_MID_HIGH) begin
        s_d.cfg.mask_mid_high = REG_WDATA;
      end else if (REG_ADDR == CWFF_ADDR_WAKE_MASK_MID_LOW) begin
        s_d.cfg.mask_mid_low = REG_WDATA;
      end else if (REG_ADDR == CWFF_ADDR_WAKE_MASK_LOW) begin
        s_d.cfg.mask_low = REG_WDATA[CWFF_POS_ID_LOW_MSB:CWFF_POS_ID_LOW_LSB];
      end else if (REG_ADDR == CWFF_ADDR_WAKE_LENGTH_CODE) begin
        s_d.cfg.dlc = REG_WDATA[CWFF_POS_DLC_MSB:0];
      end
    end
    if (REG_RD) begin
      s_d.rdata = read_reg(REG_ADDR, s_q.cfg);
    end
    // Clearing wins over a set in the same cycle: a stale config must never look valid
    if (CFG_VALID_SET) begin
      s_d.cfg_valid = 1'b1;
    end
    if (cfg_write || match || WAKE_EVENT) begin
      s_d.cfg_valid = 1'b0;
    end
    if (SOFT_RST) begin
      s_d.cfg = '0;
      s_d.cfg.id_top = CFG_ID_TOP;
      s_d.cfg_valid = 1'b0;
      s_d.rdata = CWFF_RST_BYTE;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // The top identifier byte is owned elsewhere; it is used live, not from the copy registered in s_q
  always_comb begin
    cfg_live = s_q.cfg;
    cfg_live.id_top = CFG_ID_TOP;
    frame.id = FRAME_ID;
    frame.ide = FRAME_IDE;
    frame.rtr = FRAME_RTR;
    frame.dlc = FRAME_DLC;
  end

  cwff_match u_match (
    .clk(MCLK),
    .rst_n(RST_N),
    .enable(s_q.cfg_valid),
    .cfg(cfg_live),
    .frame_valid(FRAME_VALID),
    .frame(frame),
    .match(match)
  );

  assign REG_RDATA = s_q.rdata;
  assign CONFIG_VALID_FLAG = s_q.cfg_valid;
  assign WAKE_MATCH = match;

endmodule : cwff_top

//--- bench/cwff_checker.sv
module cwff_checker
  import cwff_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SOFT_RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic CFG_VALID_SET,
  input wire logic WAKE_EVENT,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic [7:0] CFG_ID_TOP,
  input wire logic CONFIG_VALID_FLAG,
  input wire logic FRAME_VALID,
  input wire logic FRAME_IDE,
  input wire logic FRAME_RTR,
  input wire logic WAKE_MATCH,
  input wire logic [28:0] FRAME_ID,
  input wire logic [3:0] FRAME_DLC
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  logic in_map, clr;
  assign in_map = REG_ADDR >= 7'h24 && REG_ADDR <= 7'h2b;
  assign clr = (REG_WR && in_map) || WAKE_EVENT || WAKE_MATCH || SOFT_RST;
  sequence s_set;
    CFG_VALID_SET && !clr;
  endsequence
  sequence s_match_clear;
    WAKE_MATCH ##1 !CONFIG_VALID_FLAG;
  endsequence
  a_match_has_cause: assert property (WAKE_MATCH |-> $past(FRAME_VALID && CONFIG_VALID_FLAG))
    else $error("match without a taken frame");
  a_match_clears_flag: assert property (WAKE_MATCH |-> s_match_clear) else $error("flag kept after match");
  a_write_clears_flag: assert property ((REG_WR && in_map) || WAKE_EVENT |=> !CONFIG_VALID_FLAG)
    else $error("flag kept after write or wake");
  a_set_raises_flag: assert property (s_set |=> CONFIG_VALID_FLAG) else $error("flag not set");
  a_refused_frame: assert property (FRAME_VALID && !CONFIG_VALID_FLAG |=> !WAKE_MATCH)
    else $error("match while not valid");
  a_soft_reset_clears: assert property (SOFT_RST |=> REG_RDATA == 8'h00 && !CONFIG_VALID_FLAG)
    else $error("soft reset left state");
  a_mask_low_rsv: assert property (REG_RD && REG_ADDR == CWFF_ADDR_WAKE_MASK_LOW |=> (REG_RDATA & 8'h83) == 8'h00)
    else $error("mask reserved bits set");
  a_dlc_rsv: assert property (REG_RD && REG_ADDR == CWFF_ADDR_WAKE_LENGTH_CODE |=> REG_RDATA[7:4] == 4'h0)
    else $error("length reserved bits set");
  a_unmapped_zero: assert property (REG_RD && !in_map |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
endmodule : cwff_checker

bind cwff_top cwff_checker u_chk (.MCLK(MCLK), .RST_N(RST_N), .SOFT_RST(SOFT_RST), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .CFG_VALID_SET(CFG_VALID_SET), .WAKE_EVENT(WAKE_EVENT), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CFG_ID_TOP(CFG_ID_TOP), .CONFIG_VALID_FLAG(CONFIG_VALID_FLAG),
  .FRAME_VALID(FRAME_VALID), .FRAME_IDE(FRAME_IDE), .FRAME_RTR(FRAME_RTR), .WAKE_MATCH(WAKE_MATCH),
  .FRAME_ID(FRAME_ID), .FRAME_DLC(FRAME_DLC));

//--- bench/cwff_node.sv
module cwff_node
  import cwff_pkg::*;
(
  input wire logic clk,
  input wire logic send,
  input cwff_frame_t f,
  output logic valid,
  output cwff_frame_t bus
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    valid = 1'b0;
    bus = '0;
  end
  // Idle fields toggle so a stale frame can never pass for a fresh one
  always @(posedge clk) begin
    valid <= #1 send;
    bus <= #1 send ? f : ~bus;
  end
endmodule : cwff_node

//--- bench/tb_top.sv
module tb_top;
  import cwff_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic MCLK = 1'b0, RST_N = 1'b0, SOFT_RST = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, CFG_VALID_SET = 1'b0;
  logic WAKE_EVENT = 1'b0, send = 1'b0, CONFIG_VALID_FLAG, FRAME_VALID, WAKE_MATCH;
  logic [6:0] REG_ADDR = 7'h00;
  logic [7:0] REG_WDATA = 8'h00, REG_RDATA;
  logic [7:0] CFG_ID_TOP = 8'hc3;
  cwff_frame_t f = '0, fbus;
  int n_errors = 0, tests_run = 0, cyc = 0;
  localparam logic [28:0] CID = {8'hc3, 8'ha5, 8'h3c, 5'h15};
  always #4 MCLK = ~MCLK;
  cwff_top u_dut (.MCLK(MCLK), .RST_N(RST_N), .SOFT_RST(SOFT_RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CFG_ID_TOP(CFG_ID_TOP),
    .CFG_VALID_SET(CFG_VALID_SET), .WAKE_EVENT(WAKE_EVENT), .CONFIG_VALID_FLAG(CONFIG_VALID_FLAG),
    .FRAME_VALID(FRAME_VALID), .FRAME_ID(fbus.id), .FRAME_IDE(fbus.ide), .FRAME_RTR(fbus.rtr),
    .FRAME_DLC(fbus.dlc), .WAKE_MATCH(WAKE_MATCH));
  cwff_node u_node (.clk(MCLK), .send(send), .f(f), .valid(FRAME_VALID), .bus(fbus));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : step
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    step(1);
    REG_WR = 1'b0;
    // Idle cycle so back-to-back calls never re-raise the strobe in the same step
    step(1);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    REG_ADDR = a;
    REG_RD = 1'b1;
    step(1);
    REG_RD = 1'b0;
    check("reg_rdata", REG_RDATA, exp);
    step(1);
  endtask : rd
  // Mode 0 leaves the flag alone, 1 sets it, 2 sets it and then wakes
  task automatic frame(input int mode, input logic [28:0] id, input logic ide, rtr, input logic [3:0] dlc,
    input logic exp);
    CFG_VALID_SET = (mode != 0);
    step(1);
    check("config_valid_flag", {7'h00, CONFIG_VALID_FLAG}, {7'h00, mode != 0});
    CFG_VALID_SET = 1'b0;
    WAKE_EVENT = (mode == 2);
    f = '{id, ide, rtr, dlc};
    send = 1'b1;
    step(1);
    WAKE_EVENT = 1'b0;
    send = 1'b0;
    step(1);
    check("wake_match", {7'h00, WAKE_MATCH}, {7'h00, exp});
    step(2);
    check("config_valid_flag", {7'h00, CONFIG_VALID_FLAG}, {7'h00, (mode == 1) && !exp});
  endtask : frame
  task automatic t_regs;
    logic [7:0] rmask [8] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h7c, 8'h0f};
    for (int i = 0; i < 8; i++) begin
      rd(7'h24 + 7'(i), 8'h00);
      wr(7'h24 + 7'(i), 8'hff);
      rd(7'h24 + 7'(i), rmask[i]);
    end
    wr(7'h2c, 8'hff);
    rd(7'h2c, 8'h00);
    SOFT_RST = 1'b1;
    step(1);
    SOFT_RST = 1'b0;
    rd(7'h24, 8'h00);
    rd(7'h2a, 8'h00);
    wr(7'h25, 8'h5a);
    RST_N = 1'b0;
    step(2);
    RST_N = 1'b1;
    step(1);
    rd(7'h25, 8'h00);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_match;
    logic [7:0] cfg [8] = '{8'ha5, 8'h3c, 8'h55, 8'hff, 8'hff, 8'hf0, 8'h7c, 8'h08};
    for (int i = 0; i < 8; i++) wr(7'h24 + 7'(i), cfg[i]);
    frame(1, CID, 1'b1, 1'b0, 4'h8, 1'b1);
    frame(0, CID, 1'b1, 1'b0, 4'h8, 1'b0);
    frame(1, CID ^ 29'h20, 1'b1, 1'b0, 4'h8, 1'b1);
    frame(1, CID ^ 29'h200, 1'b1, 1'b0, 4'h8, 1'b0);
    frame(2, CID, 1'b1, 1'b0, 4'h8, 1'b0);
    frame(1, CID ^ 29'h1, 1'b1, 1'b0, 4'h8, 1'b0);
    frame(1, CID ^ 29'h10000000, 1'b1, 1'b0, 4'h8, 1'b0);
    frame(1, CID, 1'b1, 1'b0, 4'h9, 1'b0);
    frame(1, CID, 1'b0, 1'b0, 4'h8, 1'b0);
    frame(1, CID, 1'b1, 1'b1, 4'h8, 1'b0);
    wr(7'h26, 8'h54);
    frame(1, CID ^ 29'h3ffff, 1'b0, 1'b0, 4'h8, 1'b1);
    frame(1, CID ^ 29'h40000, 1'b0, 1'b0, 4'h8, 1'b0);
    CFG_ID_TOP = 8'h3c;
    frame(1, CID, 1'b0, 1'b0, 4'h8, 1'b0);
    frame(1, {8'h3c, CID[20:0]}, 1'b0, 1'b0, 4'h8, 1'b1);
    $display("t_match done");
  endtask : t_match
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    step(10);
    RST_N = 1'b1;
    step(1);
    t_regs();
    t_match();
    conclude();
  end
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end
endmodule : tb_top
